// File: vec_fp_pkg.sv
package vec_fp_pkg;

   // ----------------------------------------------------------------
   // Register map (byte offsets, low address bits only)
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  ADDR_A_HI     = 8'h00;
   localparam logic [7:0]  ADDR_A_LO     = 8'h04;
   localparam logic [7:0]  ADDR_B_HI     = 8'h08;
   localparam logic [7:0]  ADDR_B_LO     = 8'h0C;
   localparam logic [7:0]  ADDR_D_HI     = 8'h10;
   localparam logic [7:0]  ADDR_D_LO     = 8'h14;
   localparam logic [7:0]  ADDR_CTRL     = 8'h18;
   localparam logic [7:0]  ADDR_STATUS   = 8'h1C;
   localparam int          CTRL_W        = 8;
   localparam int          CTRL_GO_BIT   = 8;
   localparam int          STAT_W        = 13;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HRESP_OKAY    = 2'h0;

   // ----------------------------------------------------------------
   // Single-precision field constants
   // ----------------------------------------------------------------
   localparam logic [7:0]         EXP_ALL_ONES = 8'hFF;
   localparam logic [7:0]         EXP_ZERO     = 8'h00;
   localparam logic [31:0]        PMAX         = 32'h7F7FFFFF;
   localparam logic [31:0]        NMAX         = 32'hFF7FFFFF;
   localparam logic signed [10:0] EXP_BIAS     = 11'sh07F;
   localparam logic signed [10:0] EXP_FLOOR    = -11'sh200;
   localparam logic signed [10:0] EXP_OVF      = 11'sh0FF;
   localparam logic signed [10:0] EXP_UNF      = 11'sh000;
   localparam logic signed [10:0] NORM_POS     = 11'sh03E;
   localparam logic [10:0]        SHIFT_MAX    = 11'h03F;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_MADD = 2'h0,
      OP_MSUB = 2'h1,
      OP_MIN  = 2'h3,
      OP_MAX  = 2'h2
   } op_t;

   typedef enum logic [1:0] {
      round_to_nearest       = 2'h0,
      round_toward_zero      = 2'h1,
      round_toward_plus_inf  = 2'h2,
      round_toward_minus_inf = 2'h3
   } rmode_t;

   // Control word, bits [7:0] of the control register
   typedef struct packed {
      logic   inexact_exception_enable;
      logic   underflow_exception_enable;
      logic   overflow_exception_enable;
      logic   invalid_exception_enable;
      rmode_t rmode;
      op_t    op;
   } ctrl_t;

   // Status word, bits [12:0] of vector_float_status_control
   typedef struct packed {
      logic round_exception;
      logic exception_taken;
      logic sticky_bit_high;
      logic guard_bit_high;
      logic sticky_bit_low;
      logic guard_bit_low;
      logic inexact_sticky_flag;
      logic underflow_flag_high;
      logic underflow_flag_low;
      logic overflow_flag_high;
      logic overflow_flag_low;
      logic invalid_flag_high;
      logic invalid_flag_low;
   } status_t;

   // Per-half arithmetic outcome
   typedef struct packed {
      logic [31:0] val;
      logic        ovf;
      logic        unf;
      logic        inx;
      logic        grd;
      logic        stk;
   } half_res_t;

endpackage : vec_fp_pkg

// File: vector_sp_fma_minmax_unit.sv
`timescale 1ns/100ps

// Behaviour
// RQ1: Multiply-add: each A half times B half plus old D half, into D.
// RQ2: Zero or denormal multiplicand gives zero product with product's sign.
// RQ3: NaN/infinite multiplicand: result is pmax if signs match, else nmax.
// RQ4: NaN/infinite old D half: pmax for sign 0, nmax for sign 1.
// RQ5: Overflow saturates signed; underflow gives +0, or -0 when rounding down.
// RQ6: Infinite, denormal or NaN input sets that half's invalid flag, clears guard/sticky.
// RQ7: Invalid with invalid enable raises exception, destination kept.
// RQ8: Otherwise overflow and underflow set per-half flags.
// RQ9: Enabled overflow/underflow with flag set raises exception, destination kept.
// RQ10: Inexact, or disabled overflow/underflow, sets inexact sticky when no exception.
// RQ11: Inexact enable raises round exception, writes truncated result, updates guard/sticky.
// RQ12: Maximum writes larger half per position, high and low separately.
// RQ13: Maximum of +0 and -0 is +0.
// RQ14: Minimum writes smaller half; minimum of +0 and -0 is -0.
// RQ15: Max/min special inputs flag invalid; enabled invalid keeps destination.
// RQ16: Max/min compare special values by raw exponent and fraction.
// RQ17: Exactly one NaN: the other half is selected.
// RQ18: Selected denormal becomes zero of its sign.
// RQ19: Selected positive NaN or infinity becomes pmax.
// RQ20: Multiply-subtract: product minus old D half, into D.
// RQ21: Max/min pair halves strictly by position.
// RQ22: Inexact with enable also updates guard and sticky bits.
// RQ23: High-suffixed flags report bits 0:31, plain flags bits 32:63.
// RQ24: Multiply-subtract uses same saturation and signed-zero underflow policy.
module vector_sp_fma_minmax_unit (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic             done_out,
   output logic             exception_out,
   output logic             round_exception_out
);

   // ----------------------------------------------------------------
   // Operand classification
   // ----------------------------------------------------------------
   function automatic logic is_naninf(input logic [31:0] x);
      return x[30:23] == vec_fp_pkg::EXP_ALL_ONES;
   endfunction : is_naninf
   function automatic logic is_nan(input logic [31:0] x);
      return is_naninf(x) && (x[22:0] != 23'h000000);
   endfunction : is_nan
   function automatic logic is_denorm(input logic [31:0] x);
      return (x[30:23] == vec_fp_pkg::EXP_ZERO) && (x[22:0] != 23'h000000);
   endfunction : is_denorm
   function automatic logic is_invalid(input logic [31:0] x);
      return is_naninf(x) || is_denorm(x);
   endfunction : is_invalid

   // ----------------------------------------------------------------
   // Fused multiply-add/subtract of one half, truncated
   // ----------------------------------------------------------------
   function automatic vec_fp_pkg::half_res_t fma_half(input logic [31:0] a,
                                                      input logic [31:0] b,
                                                      input logic [31:0] d,
                                                      input logic sub,
                                                      input vec_fp_pkg::rmode_t rm);
      vec_fp_pkg::half_res_t r;
      logic                  ps, sd, sbig, ssml, swap, lost;
      logic [47:0]           prod, mp, md;
      logic signed [10:0]    ep, edd, ebig, esml, er;
      logic [10:0]           diff;
      logic [5:0]            sh;
      logic [63:0]           xb, xs, s, n;
      int                    pos;
      r    = '0;
      pos  = 0;
      ps   = a[31] ^ b[31];
      sd   = d[31] ^ sub;
      // RQ3: special multiplicand saturates
      if ((is_naninf(a) || is_naninf(b)) && (|a[30:23]) && (|b[30:23]))
         r.val = ps ? vec_fp_pkg::NMAX : vec_fp_pkg::PMAX;
      // RQ4: special addend saturates by its sign
      else if (is_naninf(d))
         r.val = d[31] ? vec_fp_pkg::NMAX : vec_fp_pkg::PMAX;
      else
      begin
         prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
         ep   = $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]}) - vec_fp_pkg::EXP_BIAS;
         mp   = prod[47] ? prod : {prod[46:0], 1'b0};
         ep   = prod[47] ? ep + 11'sh001 : ep;
         // RQ2: zero or denormal multiplicand, signed zero product
         if ((a[30:23] == vec_fp_pkg::EXP_ZERO) || (b[30:23] == vec_fp_pkg::EXP_ZERO))
         begin
            mp = '0;
            ep = vec_fp_pkg::EXP_FLOOR;
         end
         md  = (d[30:23] == vec_fp_pkg::EXP_ZERO) ? 48'h0 : {1'b1, d[22:0], 24'h000000};
         edd = (d[30:23] == vec_fp_pkg::EXP_ZERO) ? vec_fp_pkg::EXP_FLOOR : $signed({3'h0, d[30:23]});
         // Larger magnitude leads the alignment
         swap = (edd > ep) || ((edd == ep) && (md > mp));
         ebig = swap ? edd : ep;
         esml = swap ? ep : edd;
         sbig = swap ? sd : ps;
         ssml = swap ? ps : sd;
         xb   = {1'b0, (swap ? md : mp), 15'h0000};
         xs   = {1'b0, (swap ? mp : md), 15'h0000};
         diff = 11'(ebig - esml);
         sh   = (diff > vec_fp_pkg::SHIFT_MAX) ? 6'(vec_fp_pkg::SHIFT_MAX) : diff[5:0];
         lost = (xs & ~({64{1'b1}} << sh)) != 64'h0;
         // RQ1: add; RQ20: subtract via flipped addend sign
         if (sbig == ssml)
            s = xb + (xs >> sh);
         else
            s = xb - (xs >> sh) - {63'h0, lost};
         if (s == 64'h0)
            r.val = {(sbig == ssml) ? sbig : (rm == vec_fp_pkg::round_toward_minus_inf), 31'h0};
         else
         begin
            for (int i = 0; i < 64; i++)
               if (s[i])
                  pos = i;
            n     = s << 6'(63 - pos);
            er    = ebig + 11'(pos) - vec_fp_pkg::NORM_POS;
            r.grd = n[39];
            r.stk = (n[38:0] != 39'h0) || lost;
            r.inx = r.grd || r.stk;
            // RQ5: signed saturation on overflow
            // RQ24: same policy for subtract
            if (er >= vec_fp_pkg::EXP_OVF)
            begin
               r.val = sbig ? vec_fp_pkg::NMAX : vec_fp_pkg::PMAX;
               r.ovf = 1'b1;
            end
            // RQ5: underflow zero sign from rounding mode
            else if (er <= vec_fp_pkg::EXP_UNF)
            begin
               r.val = {(rm == vec_fp_pkg::round_toward_minus_inf), 31'h0};
               r.unf = 1'b1;
            end
            else
               r.val = {sbig, er[7:0], n[62:40]};
         end
      end
      return r;
   endfunction : fma_half

   // ----------------------------------------------------------------
   // Maximum/minimum of one half
   // ----------------------------------------------------------------
   function automatic logic raw_less(input logic [31:0] a, input logic [31:0] b);
      // RQ16: raw sign-magnitude order
      if (a[31] != b[31])
         return a[31];
      return a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
   endfunction : raw_less

   function automatic logic [31:0] minmax_half(input logic [31:0] a,
                                              input logic [31:0] b,
                                              input logic take_max);
      logic [31:0] t;
      // RQ13: -0 orders below +0 for maximum
      // RQ14: smaller selected for minimum
      t = (raw_less(a, b) == take_max) ? b : a;
      // RQ17: prefer the non-NaN half
      if (is_nan(a) && !is_nan(b))
         t = b;
      if (is_nan(b) && !is_nan(a))
         t = a;
      // RQ18: denormal becomes signed zero
      if (is_denorm(t))
         t = {t[31], 31'h0};
      // RQ19: NaN or infinity becomes pmax, or nmax when negative
      else if (is_naninf(t))
         t = t[31] ? vec_fp_pkg::NMAX : vec_fp_pkg::PMAX;
      return t;
   endfunction : minmax_half

   // ----------------------------------------------------------------
   // Registers and bus pipeline state
   // ----------------------------------------------------------------
   logic [63:0]                   a_q, b_q, d_q, d_d;
   vec_fp_pkg::ctrl_t             ctrl_q;
   vec_fp_pkg::status_t           stat_q, stat_d;
   logic                          wr_d, go_q, wr_pend_q, rd_pend_q, addr_take, stat_wr;
   logic [vec_fp_pkg::ADDR_W-1:0] wr_addr_q, rd_addr_q;
   vec_fp_pkg::half_res_t         fr_hi, fr_lo;
   logic                          inv_hi, inv_lo, inx_hi, inx_lo, is_fma, exc_d, rexc_d;

   // Address phase taken when selected, ready and NONSEQ
   assign addr_take = hsel_in && hready_in && (htrans_in == vec_fp_pkg::HTRANS_NONSEQ);
   assign stat_wr   = wr_pend_q && (wr_addr_q == vec_fp_pkg::ADDR_STATUS);
   assign is_fma    = (ctrl_q.op == vec_fp_pkg::OP_MADD) || (ctrl_q.op == vec_fp_pkg::OP_MSUB);

   // ----------------------------------------------------------------
   // Bus slave: address capture, read wait state, response
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         wr_pend_q     <= 1'b0;
         rd_pend_q     <= 1'b0;
         wr_addr_q     <= '0;
         rd_addr_q     <= '0;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
      else
      begin
         wr_pend_q     <= addr_take && hwrite_in;
         rd_pend_q     <= addr_take && !hwrite_in;
         hresp_out     <= vec_fp_pkg::HRESP_OKAY[0];
         hreadyout_out <= !(addr_take && !hwrite_in);
         if (addr_take)
         begin
            wr_addr_q <= haddr_in[vec_fp_pkg::ADDR_W-1:0];
            rd_addr_q <= haddr_in[vec_fp_pkg::ADDR_W-1:0];
         end
      end
   end

   // Read data sampled in the wait cycle, after any earlier write landed
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         hrdata_out <= 32'h00000000;
      else if (rd_pend_q)
         unique case (rd_addr_q)
            vec_fp_pkg::ADDR_A_HI:   hrdata_out <= a_q[63:32];
            vec_fp_pkg::ADDR_A_LO:   hrdata_out <= a_q[31:0];
            vec_fp_pkg::ADDR_B_HI:   hrdata_out <= b_q[63:32];
            vec_fp_pkg::ADDR_B_LO:   hrdata_out <= b_q[31:0];
            vec_fp_pkg::ADDR_D_HI:   hrdata_out <= d_q[63:32];
            vec_fp_pkg::ADDR_D_LO:   hrdata_out <= d_q[31:0];
            vec_fp_pkg::ADDR_CTRL:   hrdata_out <= {24'h000000, ctrl_q};
            vec_fp_pkg::ADDR_STATUS: hrdata_out <= {19'h00000, stat_q};
            default:                 hrdata_out <= 32'h00000000;
         endcase
   end

   // ----------------------------------------------------------------
   // Operand and control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         a_q    <= 64'h0;
         b_q    <= 64'h0;
         ctrl_q <= '0;
         go_q   <= 1'b0;
      end
      else
      begin
         go_q <= wr_pend_q && (wr_addr_q == vec_fp_pkg::ADDR_CTRL) && hwdata_in[vec_fp_pkg::CTRL_GO_BIT];
         if (wr_pend_q)
            unique case (wr_addr_q)
               vec_fp_pkg::ADDR_A_HI: a_q[63:32] <= hwdata_in;
               vec_fp_pkg::ADDR_A_LO: a_q[31:0]  <= hwdata_in;
               vec_fp_pkg::ADDR_B_HI: b_q[63:32] <= hwdata_in;
               vec_fp_pkg::ADDR_B_LO: b_q[31:0]  <= hwdata_in;
               vec_fp_pkg::ADDR_CTRL: ctrl_q     <= vec_fp_pkg::ctrl_t'(hwdata_in[vec_fp_pkg::CTRL_W-1:0]);
               default:               ;
            endcase
      end
   end

   // Destination: execution write-back wins over a bus write
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         d_q <= 64'h0;
      else if (go_q && wr_d)
         d_q <= d_d;
      else if (wr_pend_q && (wr_addr_q == vec_fp_pkg::ADDR_D_HI))
         d_q[63:32] <= hwdata_in;
      else if (wr_pend_q && (wr_addr_q == vec_fp_pkg::ADDR_D_LO))
         d_q[31:0] <= hwdata_in;
   end

   // ----------------------------------------------------------------
   // Datapath: both halves in parallel
   // ----------------------------------------------------------------
   // RQ23: high half is bits 0:31, held in [63:32]
   assign fr_hi = fma_half(a_q[63:32], b_q[63:32], d_q[63:32], ctrl_q.op == vec_fp_pkg::OP_MSUB, ctrl_q.rmode);
   assign fr_lo = fma_half(a_q[31:0], b_q[31:0], d_q[31:0], ctrl_q.op == vec_fp_pkg::OP_MSUB, ctrl_q.rmode);

   // Exception priority and status/result selection
   always_comb
   begin
      stat_d                     = '0;
      stat_d.inexact_sticky_flag = stat_q.inexact_sticky_flag;
      d_d                    = d_q;
      wr_d                   = 1'b0;
      exc_d                  = 1'b0;
      rexc_d                 = 1'b0;
      // RQ6: per-half invalid detection
      // RQ15: same for max/min
      inv_hi = is_invalid(a_q[63:32]) || is_invalid(b_q[63:32]) || (is_fma && is_invalid(d_q[63:32]));
      inv_lo = is_invalid(a_q[31:0]) || is_invalid(b_q[31:0]) || (is_fma && is_invalid(d_q[31:0]));
      inx_hi = fr_hi.inx || (fr_hi.ovf && !ctrl_q.overflow_exception_enable)
               || (fr_hi.unf && !ctrl_q.underflow_exception_enable);
      inx_lo = fr_lo.inx || (fr_lo.ovf && !ctrl_q.overflow_exception_enable)
               || (fr_lo.unf && !ctrl_q.underflow_exception_enable);
      stat_d.invalid_flag_high   = inv_hi;
      stat_d.invalid_flag_low    = inv_lo;
      // RQ7: enabled invalid blocks the write
      if ((inv_hi || inv_lo) && ctrl_q.invalid_exception_enable)
         exc_d = 1'b1;
      else if (is_fma)
      begin
         // RQ8: per-half overflow and underflow flags
         stat_d.overflow_flag_high  = fr_hi.ovf;
         stat_d.overflow_flag_low   = fr_lo.ovf;
         stat_d.underflow_flag_high = fr_hi.unf;
         stat_d.underflow_flag_low  = fr_lo.unf;
         // RQ9: enabled overflow/underflow blocks the write
         if ((ctrl_q.overflow_exception_enable && (fr_hi.ovf || fr_lo.ovf))
             || (ctrl_q.underflow_exception_enable && (fr_hi.unf || fr_lo.unf)))
            exc_d = 1'b1;
         else
         begin
            wr_d = 1'b1;
            d_d  = {fr_hi.val, fr_lo.val};
            // RQ10: inexact sticky
            if (inx_hi || inx_lo)
            begin
               stat_d.inexact_sticky_flag = 1'b1;
               // RQ11: round exception, truncated write stands
               rexc_d = ctrl_q.inexact_exception_enable;
            end
            // RQ22: guard/sticky kept for handler rounding
            // RQ6: invalid inputs leave them cleared
            if (!(inv_hi || inv_lo))
            begin
               stat_d.guard_bit_high  = fr_hi.grd;
               stat_d.sticky_bit_high = fr_hi.stk;
               stat_d.guard_bit_low   = fr_lo.grd;
               stat_d.sticky_bit_low  = fr_lo.stk;
            end
         end
      end
      else
      begin
         // RQ12, RQ14: maximum or minimum per half
         // RQ21: same-position halves only
         wr_d = 1'b1;
         d_d  = {minmax_half(a_q[63:32], b_q[63:32], ctrl_q.op == vec_fp_pkg::OP_MAX),
                 minmax_half(a_q[31:0], b_q[31:0], ctrl_q.op == vec_fp_pkg::OP_MAX)};
      end
      stat_d.exception_taken = exc_d;
      stat_d.round_exception = rexc_d;
   end

   // ----------------------------------------------------------------
   // Status register and event pulses
   // ----------------------------------------------------------------
   // Inexact sticky: a set on execution wins over a same-cycle bus clear
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         stat_q <= '0;
      else if (go_q)
      begin
         stat_q                     <= stat_d;
         stat_q.inexact_sticky_flag <= stat_d.inexact_sticky_flag
                                       || (stat_wr ? hwdata_in[6] : stat_q.inexact_sticky_flag);
      end
      else if (stat_wr)
         stat_q <= vec_fp_pkg::status_t'(hwdata_in[vec_fp_pkg::STAT_W-1:0]);
   end

   // One-cycle pulses when an operation completes
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         done_out            <= 1'b0;
         exception_out       <= 1'b0;
         round_exception_out <= 1'b0;
      end
      else
      begin
         done_out            <= go_q;
         exception_out       <= go_q && exc_d;
         round_exception_out <= go_q && rexc_d;
      end
   end

endmodule : vector_sp_fma_minmax_unit

// File: vec_fp_chk.sv
`timescale 1ns/100ps
// ------------------------------
// Bus and completion checks
// ------------------------------
module vec_fp_chk (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic        done_out,
   input wire logic        exception_out,
   input wire logic        round_exception_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Read address phase, and a control write carrying go
   sequence s_rd;
      hreadyout_out && htrans_in == vec_fp_pkg::HTRANS_NONSEQ && !hwrite_in;
   endsequence
   sequence s_go;
      hreadyout_out && htrans_in == vec_fp_pkg::HTRANS_NONSEQ && hwrite_in
      && haddr_in[7:0] == vec_fp_pkg::ADDR_CTRL ##1 hwdata_in[8];
   endsequence
   a_read_one_wait: assert property (s_rd |=> !hreadyout_out ##1 hreadyout_out) else $error("read wait wrong");
   a_ready_back: assert property (!hreadyout_out |=> hreadyout_out) else $error("wait state too long");
   a_resp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
   a_go_done: assert property (s_go |-> ##2 done_out) else $error("no done after go");
   a_done_has_go: assert property (done_out |-> $past(hwdata_in[8], 2)) else $error("done without go");
   a_done_pulse: assert property (done_out |=> !done_out) else $error("done not a pulse");
   a_exc_done: assert property (exception_out |-> done_out) else $error("exception outside done");
   a_round_alone: assert property (round_exception_out |-> done_out && !exception_out) else $error("round bad");
endmodule : vec_fp_chk
bind vector_sp_fma_minmax_unit vec_fp_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out), .done_out(done_out), .exception_out(exception_out),
   .round_exception_out(round_exception_out));

// File: vec_issue_model.sv
`timescale 1ns/100ps
// ------------------------------
// Issue-side bus master
// ------------------------------
module vec_issue_model (
   input  wire logic        clk_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_in,
   output logic             hsel_out,
   output logic [31:0]      haddr_out,
   output logic [1:0]       htrans_out,
   output logic             hwrite_out,
   output logic [31:0]      hwdata_out
);
   initial
   begin
      hsel_out = 1'b1;
      haddr_out = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hwdata_out = 32'h0;
   end
   // One word: address phase, data phase, then stale data inverted
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_in);
      haddr_out <= {24'h0, a};
      htrans_out <= vec_fp_pkg::HTRANS_NONSEQ;
      hwrite_out <= w;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      rd = hrdata_in;
      hwdata_out <= ~wd;
   endtask : xfer
endmodule : vec_issue_model

// File: vector_sp_fma_minmax_unit_tb_top.sv
`timescale 1ns/100ps
// ------------------------------
// Testbench top
// ------------------------------
module vector_sp_fma_minmax_unit_tb_top;
   logic        clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        hsel, hwrite, hready, hresp, done, exc, rexc;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   int          err_count = 0;
   int          checks_done = 0;
   always #5 clk_in = ~clk_in;
   vec_issue_model bus (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));
   vector_sp_fma_minmax_unit dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .done_out(done),
      .exception_out(exc), .round_exception_out(rexc));
   task automatic report_and_stop;
      if (err_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Load operands, start, await done, check pulses, D halves and flags
   task automatic run(input logic [31:0] ah, al, bh, bl, dh, dl, input logic [7:0] ctl,
                      input logic [31:0] eh, el, input logic [12:0] est, input logic [1:0] eex);
      logic [31:0] v [6];
      logic [31:0] rd;
      int          n;
      v = '{ah, al, bh, bl, dh, dl};
      bus.xfer(vec_fp_pkg::ADDR_STATUS, 1'b1, 32'h0, rd);
      for (int i = 0; i < 6; i++)
         bus.xfer(vec_fp_pkg::ADDR_A_HI + 8'(4 * i), 1'b1, v[i], rd);
      bus.xfer(vec_fp_pkg::ADDR_CTRL, 1'b1, {23'h0, 1'b1, ctl}, rd);
      n = 0;
      do
      begin
         @(posedge clk_in);
         #1;
         n++;
      end
      while (done !== 1'b1 && n < 8);
      chk({29'h0, done, rexc, exc}, {29'h0, 1'b1, eex});
      bus.xfer(vec_fp_pkg::ADDR_D_HI, 1'b0, 32'h0, rd);
      chk(rd, eh);
      bus.xfer(vec_fp_pkg::ADDR_D_LO, 1'b0, 32'h0, rd);
      chk(rd, el);
      bus.xfer(vec_fp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
      chk(rd, {19'h0, est});
   endtask : run
   // Reset, register bus checks, then one call per operation case
   initial
   begin
      logic [31:0] rd;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      bus.xfer(vec_fp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      bus.xfer(8'h20, 1'b1, 32'hFFFFFFFF, rd);
      bus.xfer(8'h20, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      run(32'h40000000, 32'h40000000, 32'h40400000, 32'h40000000, 32'h3F800000, 32'h40800000, 8'h0D,
          32'h40A00000, 32'h80000000, 13'h000, 2'h0);
      run(32'h0, 32'h7F000000, 32'h7F800000, 32'h40000000, 32'hC0000000, 32'h0, 8'h00,
          32'hC0000000, 32'h7F7FFFFF, 13'h046, 2'h0);
      run(32'h0, 32'h7F000000, 32'h7F800000, 32'h40000000, 32'hC0000000, 32'h0, 8'h20,
          32'hC0000000, 32'h0, 13'h806, 2'h1);
      run(32'h7F800000, 32'h0, 32'h40000000, 32'h0, 32'h3F800000, 32'h0, 8'h10,
          32'h3F800000, 32'h0, 13'h802, 2'h1);
      run(32'h7F800000, 32'h3F800000, 32'h40000000, 32'h3F800000, 32'h0, 32'hFF800000, 8'h00,
          32'h7F7FFFFF, 32'hFF7FFFFF, 13'h003, 2'h0);
      run(32'h0, 32'h7FC00000, 32'h80000000, 32'h3F800000, 32'h0, 32'h0, 8'h02,
          32'h0, 32'h3F800000, 13'h001, 2'h0);
      run(32'h0, 32'h00000001, 32'h80000000, 32'h3F800000, 32'h0, 32'h0, 8'h03,
          32'h80000000, 32'h0, 13'h001, 2'h0);
      run(32'h7F800000, 32'h3F800000, 32'h3F800000, 32'h40000000, 32'h0, 32'h0, 8'h02,
          32'h7F7FFFFF, 32'h40000000, 13'h002, 2'h0);
      run(32'h3F800000, 32'h0, 32'h3F800000, 32'h0, 32'h30800000, 32'h0, 8'h80,
          32'h3F800000, 32'h0, 13'h1440, 2'h2);
      run(32'h00800000, 32'h3F800000, 32'h3F000000, 32'h3F800000, 32'h0, 32'h0, 8'h0C,
          32'h80000000, 32'h3F800000, 13'h060, 2'h0);
      report_and_stop();
   end
   // Watchdog against a hung handshake
   initial
   begin
      #20000;
      err_count++;
      report_and_stop();
   end
endmodule : vector_sp_fma_minmax_unit_tb_top
